// File: rtl/match_capture_counter_timer.sv
// Purpose: counter/timer with prescaler, two captures, four matches
// Assumes: register port strobes one cycle long, never both at once
// Notes: read data valid only in the cycle after the read strobe
//
// What this block does
// - timer mode counts cycles of clk_sys
// - 32-bit or 16-bit count and prescaler
// - selectable timer or pin-edge counter mode
// - two capture channels snapshot count, optional flag
// - capture event may clear count and prescaler
// - four match registers compared with count
// - continue-on-match keeps counting, optional flag
// - stop-on-match halts counting, optional flag
// - reset-on-match returns count to zero
// - match outputs go low, high, toggle, hold
// - dedicated capture and match pin ports
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "mcct_regs.svh"

module match_capture_counter_timer (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire mcct_pkg::reg_req_t bus_req,
   output logic [31:0] rd_data,
   input wire logic [1:0] capture_input_pin,
   output logic [3:0] match_output_pin,
   output logic irq
);
   import mcct_pkg::*;

   ctrl_t ctrl;
   ctrl_t next_ctrl;
   logic [31:0] tc;
   logic [31:0] next_tc;
   logic [31:0] pr;
   logic [31:0] pc;
   logic [31:0] next_pc;
   logic [3:0][31:0] mr;
   logic [1:0][31:0] cap;
   match_ctl_t [3:0] mcr;
   cap_ctl_t [1:0] ccr;
   logic [1:0] cap_clr;
   ext_act_t [3:0] act;
   logic [5:0] ir;
   logic [5:0] next_ir;
   logic [3:0] next_out;
   logic [3:0] m_evt;
   logic [1:0] rise;
   logic [1:0] fall;

   // address decode
   wire hit_ctrl = bus_req.addr == `OFS_CTRL;
   wire hit_count = bus_req.addr == `OFS_COUNT;
   wire hit_pre = bus_req.addr == `OFS_PRESCALE;
   wire hit_pcnt = bus_req.addr == `OFS_PCOUNT;
   wire hit_mctl = bus_req.addr == `OFS_MCTL;
   wire hit_cctl = bus_req.addr == `OFS_CCTL;
   wire hit_outctl = bus_req.addr == `OFS_OUTCTL;
   wire hit_flags = bus_req.addr == `OFS_FLAGS;
   wire hit_match = bus_req.addr[5:4] == `BLK_MATCH;
   wire hit_capt = bus_req.addr[5:3] == `BLK_CAPT;
   wire [1:0] sel_idx = bus_req.addr[3:2];

   wire wr_ctrl = bus_req.wr && hit_ctrl;
   wire wr_count = bus_req.wr && hit_count;
   wire wr_pre = bus_req.wr && hit_pre;
   wire wr_mctl = bus_req.wr && hit_mctl;
   wire wr_cctl = bus_req.wr && hit_cctl;
   wire wr_outctl = bus_req.wr && hit_outctl;
   wire wr_flags = bus_req.wr && hit_flags;
   wire wr_match = bus_req.wr && hit_match;

   // count width and count source
   wire [31:0] wmask = ctrl.width16 ? `MASK16 : `MASK32;
   wire cnt_rise = rise[ctrl.cnt_sel];
   wire cnt_fall = fall[ctrl.cnt_sel];
   wire cnt_evt = (ctrl.cnt_edge[0] & cnt_rise) | (ctrl.cnt_edge[1] & cnt_fall);
   wire active = ctrl.run && !ctrl.hold;
   wire count_cycle = active && (ctrl.cnt_mode ? cnt_evt : 1'b1);
   wire pre_done = (pc & wmask) == (pr & wmask);
   wire tick = count_cycle && pre_done;

   // match actions
   logic [3:0] m_rst_bits;
   logic [3:0] m_stop_bits;
   logic [3:0] m_irq_bits;
   logic [1:0] c_irq_bits;
   logic [1:0] cap_evt;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_mbits
         assign m_rst_bits[g] = mcr[g].rst;
         assign m_stop_bits[g] = mcr[g].stop;
         assign m_irq_bits[g] = mcr[g].irq_en;
      end
      for (g = 0; g < 2; g++) begin : g_cbits
         assign cap_evt[g] = (ccr[g].rise & rise[g]) | (ccr[g].fall & fall[g]);
         assign c_irq_bits[g] = ccr[g].irq_en;
      end
   endgenerate

   wire any_rst = |(m_evt & m_rst_bits);
   wire any_stop = |(m_evt & m_stop_bits);
   wire cap_clear = |(cap_evt & cap_clr);

   // next count values
   wire [31:0] tc_inc = (tc + 32'h0000_0001) & wmask;
   wire [31:0] pc_inc = (pc + 32'h0000_0001) & wmask;

   assign next_tc = wr_count ? (bus_req.wdata & wmask) :
                    (ctrl.hold || cap_clear) ? `RST_WORD :
                    (tick && any_rst) ? `RST_WORD :
                    tick ? tc_inc :
                    (tc & wmask);

   assign next_pc = (ctrl.hold || cap_clear || wr_count) ? `RST_WORD :
                    !count_cycle ? (pc & wmask) :
                    pre_done ? `RST_WORD :
                    pc_inc;

   // control word: a stop match clears run even when a same-cycle write sets it
   always_comb begin
      next_ctrl = wr_ctrl ? ctrl_t'(bus_req.wdata[`CTRL_W-1:0]) : ctrl;
      if (any_stop) begin
         next_ctrl.run = 1'b0;
      end
   end

   // flags: hardware set wins over software clear
   wire [5:0] flag_set = {cap_evt & c_irq_bits, m_evt & m_irq_bits};
   wire [5:0] flag_clr = wr_flags ? bus_req.wdata[5:0] : 6'h00;
   assign next_ir = (ir & ~flag_clr) | flag_set;

   pin_edge_detect u_edge (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .pins(capture_input_pin),
      .rise(rise),
      .fall(fall)
   );

   match_unit u_match (
      .tc(tc),
      .mr(mr),
      .wmask(wmask),
      .tick(tick),
      .act(act),
      .cur_out(match_output_pin),
      .m_evt(m_evt),
      .next_out(next_out)
   );

   // read selection
   logic [11:0] mctl_word;
   logic [7:0] cctl_word;
   logic [7:0] act_word;
   generate
      for (g = 0; g < 4; g++) begin : g_rdm
         assign mctl_word[3*g +: 3] = mcr[g];
         assign act_word[2*g +: 2] = act[g];
      end
      for (g = 0; g < 2; g++) begin : g_rdc
         assign cctl_word[3*g +: 3] = ccr[g];
      end
   endgenerate
   assign cctl_word[7:6] = cap_clr;

   wire [31:0] rd_mux = hit_ctrl ? {25'h0, ctrl} :
                        hit_count ? tc :
                        hit_pre ? pr :
                        hit_pcnt ? pc :
                        hit_mctl ? {20'h0, mctl_word} :
                        hit_cctl ? {24'h0, cctl_word} :
                        hit_outctl ? {20'h0, act_word, match_output_pin} :
                        hit_flags ? {26'h0, ir} :
                        hit_match ? mr[sel_idx] :
                        hit_capt ? cap[sel_idx[0]] :
                        32'h0000_0000;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ctrl <= ctrl_t'(`RST_CTRL);
         tc <= `RST_WORD;
         pc <= `RST_WORD;
         ir <= `RST_FLAGS;
         irq <= 1'b0;
         rd_data <= `RST_WORD;
         match_output_pin <= `RST_OUT;
      end else begin
         ctrl <= next_ctrl;
         tc <= next_tc;
         pc <= next_pc;
         ir <= next_ir;
         irq <= |next_ir;
         rd_data <= bus_req.rd ? rd_mux : `RST_WORD;
         match_output_pin <= wr_outctl ? bus_req.wdata[3:0] : next_out;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pr <= `RST_WORD;
         mcr <= '0;
         ccr <= '0;
         cap_clr <= 2'h0;
         for (int n = 0; n < 4; n++) begin
            act[n] <= ACT_NONE;
         end
      end else begin
         if (wr_pre) pr <= bus_req.wdata;
         if (wr_mctl) mcr <= bus_req.wdata[11:0];
         if (wr_cctl) ccr <= bus_req.wdata[5:0];
         if (wr_cctl) cap_clr <= bus_req.wdata[`CCTL_CLR_LSB +: 2];
         if (wr_outctl) begin
            for (int n = 0; n < 4; n++) begin
               act[n] <= ext_act_t'(bus_req.wdata[`OUTCTL_ACT_LSB+2*n +: 2]);
            end
         end
      end
   end

   generate
      for (g = 0; g < 4; g++) begin : g_mr
         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               mr[g] <= `RST_WORD;
            end else if (wr_match && sel_idx == g) begin
               mr[g] <= bus_req.wdata;
            end
         end
      end
      for (g = 0; g < 2; g++) begin : g_cap
         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               cap[g] <= `RST_WORD;
            end else if (cap_evt[g]) begin
               cap[g] <= tc;
            end
         end
      end
   endgenerate

   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   sequence s_plain_tick;
      tick && !any_rst && !cap_clear && !wr_count && !ctrl.hold;
   endsequence

   property p_timer_adv;
      (s_plain_tick ##0 !ctrl.cnt_mode)
         |=> tc == (($past(tc) + 1) & $past(wmask));
   endproperty
   a_timer_adv: assert property (p_timer_adv) else $error("timer did not advance");

   property p_w16;
      ctrl.width16 |=> tc[31:16] == 16'h0000;
   endproperty
   a_w16: assert property (p_w16) else $error("16-bit count overflowed");

   property p_cnt_idle;
      (ctrl.cnt_mode && !cnt_evt && !wr_count && !cap_clear && !ctrl.hold)
         |=> $stable(tc) && $stable(pc);
   endproperty
   a_cnt_idle: assert property (p_cnt_idle) else $error("counter moved without edge");

   property p_capture;
      cap_evt[0] |=> cap[0] == $past(tc);
   endproperty
   a_capture: assert property (p_capture) else $error("capture value wrong");

   property p_cap_clear;
      (cap_clear && !wr_count) |=> tc == 32'h0000_0000 && pc == 32'h0000_0000;
   endproperty
   a_cap_clear: assert property (p_cap_clear) else $error("capture did not clear");

   property p_stop;
      any_stop |=> !ctrl.run ##1 $stable(tc);
   endproperty
   a_stop: assert property (p_stop) else $error("stop match did not halt");

   property p_reset;
      (tick && any_rst && !wr_count) |=> tc == 32'h0000_0000;
   endproperty
   a_reset: assert property (p_reset) else $error("reset match did not zero");

   property p_toggle;
      (m_evt[1] && act[1] == ACT_TOGGLE && !wr_outctl)
         |=> match_output_pin[1] != $past(match_output_pin[1]);
   endproperty
   a_toggle: assert property (p_toggle) else $error("match output did not toggle");

   property p_presc;
      (count_cycle && !pre_done && !cap_clear && !wr_count)
         |=> pc == (($past(pc) + 1) & $past(wmask)) && $stable(tc);
   endproperty
   a_presc: assert property (p_presc) else $error("prescaler step wrong");

   property p_flag;
      (cap_evt[1] && ccr[1].irq_en) |=> ir[5] && irq;
   endproperty
   a_flag: assert property (p_flag) else $error("capture flag lost");

   sequence s_cont_match;
      s_plain_tick ##0 ((|m_evt) && !any_stop && !wr_ctrl);
   endsequence

   property p_continue;
      s_cont_match |=> ctrl.run && tc == (($past(tc) + 1) & $past(wmask));
   endproperty
   a_continue: assert property (p_continue) else $error("continue match broke count");

   property p_match_hit;
      (tick && ((tc ^ mr[2]) & wmask) == 32'h0000_0000) |-> m_evt[2];
   endproperty
   a_match_hit: assert property (p_match_hit) else $error("match event missed");

   sequence s_out0_hit;
      m_evt[0] && !wr_outctl;
   endsequence

   property p_out_low;
      (s_out0_hit ##0 act[0] == ACT_LOW) |=> !match_output_pin[0];
   endproperty
   a_out_low: assert property (p_out_low) else $error("match output not driven low");

   property p_out_high;
      (s_out0_hit ##0 act[0] == ACT_HIGH) |=> match_output_pin[0];
   endproperty
   a_out_high: assert property (p_out_high) else $error("match output not driven high");

   property p_out_write;
      wr_outctl |=> match_output_pin == $past(bus_req.wdata[3:0]);
   endproperty
   a_out_write: assert property (p_out_write) else $error("output write lost");

   property p_hold;
      (ctrl.hold && !wr_count) |=> tc == 32'h0000_0000 && pc == 32'h0000_0000;
   endproperty
   a_hold: assert property (p_hold) else $error("hold did not zero count");

   property p_flag_clr;
      (wr_flags && bus_req.wdata[0] && !(m_evt[0] && mcr[0].irq_en)) |=> !ir[0];
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flag clear lost");

   property p_irq_or;
      irq == (|ir);
   endproperty
   a_irq_or: assert property (p_irq_or) else $error("irq differs from flags");

endmodule

`default_nettype wire

// File: rtl/match_unit.sv
// Purpose: four count comparators and their external output actions
// Assumes: wmask gives the active width; tc and match values are cut to it here
// Notes: next_out is the pin state after this cycle's matches
`timescale 1ns/100ps
`default_nettype none

module match_unit (
   input wire logic [31:0] tc,
   input wire logic [3:0][31:0] mr,
   input wire logic [31:0] wmask,
   input wire logic tick,
   input wire mcct_pkg::ext_act_t [3:0] act,
   input wire logic [3:0] cur_out,
   output logic [3:0] m_evt,
   output logic [3:0] next_out
);
   import mcct_pkg::*;

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_ch
         wire eq = (tc & wmask) == (mr[i] & wmask);
         assign m_evt[i] = tick & eq;
         assign next_out[i] = !m_evt[i] ? cur_out[i] :
                              (act[i] == ACT_LOW) ? 1'b0 :
                              (act[i] == ACT_HIGH) ? 1'b1 :
                              (act[i] == ACT_TOGGLE) ? ~cur_out[i] :
                              cur_out[i];
      end
   endgenerate

endmodule

`default_nettype wire

// File: rtl/mcct_pkg.sv
// Purpose: shared types of the counter/timer
// Assumes: none
// Notes: offsets and values live in mcct_regs.svh
package mcct_pkg;

   typedef struct packed {
      logic cnt_sel;
      logic [1:0] cnt_edge;
      logic cnt_mode;
      logic width16;
      logic hold;
      logic run;
   } ctrl_t;

   typedef enum logic [1:0] {
      ACT_NONE = 2'b00,
      ACT_LOW = 2'b01,
      ACT_HIGH = 2'b10,
      ACT_TOGGLE = 2'b11
   } ext_act_t;

   typedef struct packed {
      logic irq_en;
      logic rst;
      logic stop;
   } match_ctl_t;

   typedef struct packed {
      logic irq_en;
      logic fall;
      logic rise;
   } cap_ctl_t;

   typedef struct packed {
      logic [5:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

endpackage

// File: rtl/mcct_regs.svh
// Purpose: register offsets, field positions and reset values of the counter/timer
// Assumes: byte addresses on a 6-bit word-aligned register port
// Notes: definitions only
`ifndef MCCT_REGS_SVH
`define MCCT_REGS_SVH

`define OFS_CTRL     6'h00
`define OFS_COUNT    6'h04
`define OFS_PRESCALE 6'h08
`define OFS_PCOUNT   6'h0C
`define OFS_MCTL     6'h10
`define OFS_CCTL     6'h14
`define OFS_OUTCTL   6'h18
`define OFS_FLAGS    6'h1C
`define BLK_MATCH    2'h2
`define BLK_CAPT     3'h6

`define CTRL_W       7
`define OUTCTL_ACT_LSB 4
`define FLAG_CAP_LSB 4
`define CCTL_CLR_LSB 6

`define RST_CTRL     7'h00
`define RST_WORD     32'h0000_0000
`define RST_OUT      4'h0
`define RST_FLAGS    6'h00
`define MASK16       32'h0000_FFFF
`define MASK32       32'hFFFF_FFFF

`endif

// File: rtl/pin_edge_detect.sv
// Purpose: rising and falling edge pulses of the two capture pins
// Assumes: pins already synchronous to clk_sys
// Notes: pulses are combinational, one cycle long
`timescale 1ns/100ps
`default_nettype none

module pin_edge_detect (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [1:0] pins,
   output logic [1:0] rise,
   output logic [1:0] fall
);

   logic [1:0] prev;

   genvar j;
   generate
      for (j = 0; j < 2; j++) begin : g_pin
         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               prev[j] <= 1'b0;
            end else begin
               prev[j] <= pins[j];
            end
         end
         assign rise[j] = pins[j] & ~prev[j];
         assign fall[j] = ~pins[j] & prev[j];
      end
   endgenerate

endmodule

`default_nettype wire

// File: sim/tb_top.sv
// Purpose: self-checking bench of the counter/timer
// Assumes: read data stands only in the cycle after the read strobe
// Notes: reads queue their expected value, a monitor compares on arrival
`timescale 1ns/100ps
`default_nettype none
`include "mcct_regs.svh"

module tb_top;
   import mcct_pkg::*;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   reg_req_t bus_req = '0;
   logic [1:0] capture_input_pin = 2'h0;
   logic [31:0] rd_data;
   logic [3:0] match_output_pin;
   logic irq;
   logic rd_d1 = 1'b0;
   logic p;
   int mismatches = 0;
   int checked = 0;
   int seed;
   int k;
   logic [31:0] v;
   logic [31:0] expq[$];
   logic [31:0] mskq[$];

   match_capture_counter_timer match_capture_counter_timer_i (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .bus_req(bus_req),
      .rd_data(rd_data),
      .capture_input_pin(capture_input_pin),
      .match_output_pin(match_output_pin),
      .irq(irq)
   );

   initial begin
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic test_done;
      $display("counts: %0d checked, %0d mismatches", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic put(input logic [5:0] a, input logic [31:0] d, input logic w, input logic r);
      @(posedge clk_sys);
      bus_req <= {a, d, w, r};
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      put(a, d, 1'b1, 1'b0);
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF);
      put(a, 32'h0, 1'b0, 1'b1);
      expq.push_back(e);
      mskq.push_back(m);
   endtask

   task automatic idle(input int n);
      repeat (n) put(6'h00, 32'h0, 1'b0, 1'b0);
   endtask

   task automatic pin(input int j, input logic val);
      put(6'h00, 32'h0, 1'b0, 1'b0);
      capture_input_pin[j] <= val;
   endtask

   // oldest noted read against the data standing one cycle after the strobe
   always @(posedge clk_sys) begin
      if (rd_d1) begin
         chk("read data", expq[0] & mskq[0], rd_data & mskq[0]);
         void'(expq.pop_front());
         void'(mskq.pop_front());
      end
      rd_d1 <= bus_req.rd;
   end

   initial begin
      #200000;
      mismatches++;
      test_done();
   end

   initial begin
      seed = 32'h9F6C7FF1;
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      chk("pins after reset", 32'h0, {28'h0, match_output_pin});
      chk("irq after reset", 32'h0, {31'h0, irq});
      rd(`OFS_CTRL, 32'h0);
      rd(`OFS_COUNT, 32'h0);
      rd(`OFS_FLAGS, 32'h0);
      wr(6'h38, 32'hFFFF_FFFF);
      rd(6'h38, 32'h0);
      v = $random(seed);
      wr(`OFS_PRESCALE, v);
      wr(6'h2C, ~v);
      wr(`OFS_PCOUNT, v);
      rd(`OFS_PRESCALE, v);
      rd(6'h2C, ~v);
      rd(`OFS_PCOUNT, 32'h0);
      wr(`OFS_OUTCTL, 32'h0000_000A);
      idle(2);
      chk("output state", 32'hA, {28'h0, match_output_pin});
      // stop on match 0, drive output 0 high
      wr(`OFS_OUTCTL, 32'h0000_0020);
      wr(`OFS_PRESCALE, 32'h0);
      wr(`OFS_COUNT, 32'h0);
      wr(6'h20, 32'h5);
      wr(`OFS_MCTL, 32'h5);
      wr(`OFS_CTRL, 32'h1);
      idle(20);
      rd(`OFS_COUNT, 32'h6);
      rd(`OFS_CTRL, 32'h0);
      rd(`OFS_FLAGS, 32'h1);
      idle(1);
      chk("pins after stop", 32'h1, {28'h0, match_output_pin});
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(`OFS_FLAGS, 32'h1);
      idle(2);
      chk("irq cleared", 32'h0, {31'h0, irq});
      // reset on match 1 with prescale limit 3, toggle output 1
      wr(`OFS_PRESCALE, 32'h3);
      wr(6'h24, 32'h3);
      wr(`OFS_MCTL, 32'h30);
      wr(`OFS_OUTCTL, 32'h0000_00C0);
      wr(`OFS_COUNT, 32'h0);
      wr(`OFS_CTRL, 32'h1);
      for (k = 0; k < 6; k++) begin
         idle(7 + k);
         rd(`OFS_COUNT, 32'h0, 32'hFFFF_FFFC);
         rd(`OFS_PCOUNT, 32'h0, 32'hFFFF_FFFC);
      end
      rd(`OFS_FLAGS, 32'h2);
      idle(1);
      // 16 cycles per reset period: three toggles in any 48 cycles
      p = match_output_pin[1];
      v = 32'h0;
      for (k = 0; k < 48; k++) begin
         idle(1);
         if (match_output_pin[1] !== p)
            v = v + 32'h1;
         p = match_output_pin[1];
      end
      chk("toggle count", 32'h3, v);
      // capture on rising edge of pin 0
      wr(`OFS_CTRL, 32'h0);
      wr(`OFS_FLAGS, 32'h3F);
      v = $random(seed);
      wr(`OFS_COUNT, v);
      wr(`OFS_CCTL, 32'h5);
      pin(0, 1'b1);
      idle(3);
      rd(6'h30, v);
      rd(`OFS_FLAGS, 32'h10);
      // falling edge of pin 0 clears count and prescaler
      wr(`OFS_CCTL, 32'h42);
      wr(`OFS_COUNT, v);
      pin(0, 1'b0);
      idle(3);
      rd(`OFS_COUNT, 32'h0);
      rd(`OFS_PCOUNT, 32'h0);
      rd(6'h30, v);
      // counter mode on rising edges of pin 1, pin 0 ignored
      wr(`OFS_CCTL, 32'h0);
      wr(`OFS_MCTL, 32'h0);
      wr(`OFS_PRESCALE, 32'h0);
      wr(`OFS_COUNT, 32'h0);
      wr(`OFS_CTRL, 32'h59);
      k = ($random(seed) & 7) + 1;
      pin(0, 1'b1);
      repeat (k) begin
         pin(1, 1'b1);
         idle(2);
         pin(1, 1'b0);
         idle(2);
      end
      rd(`OFS_COUNT, 32'(k));
      // hold zeroes the count, then capture 1 on a rising edge of pin 1
      wr(`OFS_CTRL, 32'h3);
      idle(3);
      rd(`OFS_COUNT, 32'h0);
      rd(`OFS_PCOUNT, 32'h0);
      wr(`OFS_CTRL, 32'h0);
      wr(`OFS_FLAGS, 32'h3F);
      v = $random(seed);
      wr(`OFS_COUNT, v);
      wr(`OFS_CCTL, 32'h28);
      pin(1, 1'b1);
      idle(3);
      rd(6'h34, v);
      rd(`OFS_FLAGS, 32'h20);
      idle(1);
      chk("irq on capture", 32'h1, {31'h0, irq});
      // 16-bit width wraps to zero and matches there
      wr(`OFS_CTRL, 32'h0);
      wr(`OFS_COUNT, 32'h0000_FFFF);
      wr(6'h20, 32'h0);
      wr(`OFS_MCTL, 32'h1);
      wr(`OFS_OUTCTL, 32'h0000_001F);
      wr(`OFS_CTRL, 32'h5);
      idle(6);
      rd(`OFS_COUNT, 32'h1);
      idle(3);
      chk("pins low on match", 32'hE, {28'h0, match_output_pin});
      test_done();
   end
endmodule
`default_nettype wire
